/* core/lfi_defs.svh */
// Register offsets, field positions and reset values
`ifndef LFI_DEFS_SVH
`define LFI_DEFS_SVH
`define LFI_SLAVE_ADDR        7'h36
`define LFI_OFF_HV_OPEN       8'hb0
`define LFI_OFF_LV_OPEN       8'hb1
`define LFI_OFF_HV_SHORT      8'hb2
`define LFI_OFF_LV_SHORT      8'hb3
`define LFI_OFF_FAULT_EN      8'hb4
`define LFI_OFF_HV_CFG        8'h10
`define LFI_OFF_LV_CFG        8'h11
`define LFI_OFF_FS_A          8'h20
`define LFI_OFF_HV_FB         8'h28
`define LFI_OFF_CP_CTRL       8'h2a
`define LFI_OFF_BANK_EN       8'h2b
`define LFI_OFF_BOOST_CTRL    8'h2d
`define LFI_OFF_BRT_A         8'h41
`define LFI_RST_FAULT_EN      8'h00
`define LFI_RST_HV_CFG        8'h06
`define LFI_RST_LV_CFG        8'h36
`define LFI_RST_FS            8'h13
`define LFI_RST_HV_FB         8'h07
`define LFI_RST_CP_CTRL       8'h00
`define LFI_RST_BANK_EN       8'h00
`define LFI_RST_BOOST_CTRL    8'h00
`define LFI_RST_BRT           8'h00
`define LFI_FEN_OPEN          0
`define LFI_FEN_SHORT         1
`define LFI_BANK_A            0
`define LFI_BANK_C            2
`define LFI_BANK_F            5
`define LFI_CP_GAIN_LSB       1
`define LFI_CP_GAIN_MSB       2
`define LFI_CP_GAIN_2X        2'b11
`define LFI_OVP_LSB           1
`define LFI_OVP_MSB           2
`endif

/* core/lfi_pkg.sv */
// Types shared by the fault flag and serial port logic
package lfi_pkg;
   typedef enum logic [4:0] {
      LFI_IDLE = 5'b00001,
      LFI_ADDR = 5'b00010,
      LFI_ACK  = 5'b00100,
      LFI_RD   = 5'b01000,
      LFI_SKIP = 5'b10000
   } lfi_state_t;

   // Analog comparator outputs, per sink plus three boost protection bits
   typedef struct packed {
      logic [2:0] hv_low_200mv;
      logic [2:0] hv_string_short;
      logic [5:0] lv_below_headroom;
      logic [5:0] lv_below_1v;
      logic       ovp_reached;
      logic       ovp_below_hyst;
      logic       sw_over_1a;
   } lfi_analog_t;

   typedef struct packed {
      logic [3:0] ovp_sel;
      logic [1:0] cp_gain;
      logic [2:0] hv_feedback;
      logic [2:0] hv_to_bank_a;
      logic [5:0] lv_bank_cf;
      logic [2:0] bank_en;
   } lfi_ctrl_t;

   typedef struct packed {
      logic [1:0]  scl_s;
      logic [1:0]  sda_s;
      logic        scl_d;
      logic        sda_d;
      logic [1:0]  ana_s0_pad;
      lfi_analog_t ana_s1;
      lfi_analog_t ana_s2;
      lfi_state_t  state;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [1:0]  byte_idx;
      logic        rw;
      logic        sda_low;
      logic [7:0]  reg_ptr;
      logic [7:0]  fault_en;
      logic [7:0]  hv_cfg;
      logic [7:0]  lv_cfg;
      logic [7:0]  fs_a;
      logic [7:0]  hv_fb;
      logic [7:0]  cp_ctrl;
      logic [7:0]  bank_en;
      logic [7:0]  boost_ctrl;
      logic [7:0]  brt_a;
      logic [2:0]  hv_open;
      logic [2:0]  hv_short;
      logic [5:0]  lv_open;
      logic [5:0]  lv_short;
      logic        ovp_stop;
      logic        ocp_off;
   } lfi_state_all_t;
endpackage

/* core/lfi_fault_port.sv */
// Fault flags, boost protection and two-wire slave register port
`timescale 1ns/1ps
`include "lfi_defs.svh"
// Behaviour
// - Enabled boost sink with string below supply minus 1 V sets short flag.
// - Fault enable bit 0 arms open detection, bit 1 arms short detection.
// - Boost short status bit 0 reports first boost sink short.
// - Active pump sink input below about 80 mV flags an open.
// - Pump-fed open status holds six per-sink flags in low bits.
// - Active pump LED below 1 V flags short in six low bits.
// - Output config 0x00 routes sinks 1-3 to bank C, 4-6 to F.
// - Bank enable bits 5, 2, 0 enable banks F, C and A.
// - Pump control bits 2:1 at 11 force double gain; 0x40 unity.
// - Feedback enable bits 2:0 put boost sinks into boost regulation.
// - Config bits 2:0 at 110 assign only first boost sink to A.
// - Full-scale 0x13 selects 20.2 mA; brightness 0xFF is maximum.
// - Overvoltage limit selects 16, 24, 32 or 40 V; switching stops.
// - Switching resumes once output falls 1 V below the limit.
// - Overvoltage limit resets to 16 V; host raises it if needed.
// - Switch current at 1 A ends the cycle; resume next cycle.
// - Bus busy from START to STOP; repeated START acts as START.
// - SDA changes only while SCL low, except START and STOP.
// - Slave answers address 0x36 followed by read/write bit.
// - Write byte after address selects register, next byte is data.
// - Bytes are eight bits MSB first; slave pulls SDA on ninth of each byte it accepts.
// - Fault flags stay inactive while their detection type is off.
// - Boost open flags set when sink below 200 mV at overvoltage.
module lfi_fault_port
   import lfi_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire lfi_analog_t analog_in,
   input  wire logic        pwm_cycle_start,
   output logic             boost_switch_en,
   output lfi_ctrl_t        ctrl_out,
   output logic             bus_busy
);
   lfi_state_all_t r;
   lfi_state_all_t next_r;

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [7:0] rd_data;

   // ----------------------------------------------------------------
   // Bus line conditioning
   // ----------------------------------------------------------------
   // Edges and conditions compare the second synchroniser stage with its delayed copy
   assign scl_rise   = r.scl_s[1] & ~r.scl_d;
   assign scl_fall   = ~r.scl_s[1] & r.scl_d;
   assign start_cond = r.scl_s[1] & r.scl_d & r.sda_d & ~r.sda_s[1];
   assign stop_cond  = r.scl_s[1] & r.scl_d & ~r.sda_d & r.sda_s[1];

   // ----------------------------------------------------------------
   // Read data multiplexer
   // ----------------------------------------------------------------
   // Status flags are zero-extended; unknown offsets read zero
   always_comb begin
      unique case (r.reg_ptr)
         `LFI_OFF_HV_OPEN:    rd_data = {5'h0, r.hv_open};
         `LFI_OFF_LV_OPEN:    rd_data = {2'h0, r.lv_open};
         `LFI_OFF_HV_SHORT:   rd_data = {5'h0, r.hv_short};
         `LFI_OFF_LV_SHORT:   rd_data = {2'h0, r.lv_short};
         `LFI_OFF_FAULT_EN:   rd_data = r.fault_en;
         `LFI_OFF_HV_CFG:     rd_data = r.hv_cfg;
         `LFI_OFF_LV_CFG:     rd_data = r.lv_cfg;
         `LFI_OFF_FS_A:       rd_data = r.fs_a;
         `LFI_OFF_HV_FB:      rd_data = r.hv_fb;
         `LFI_OFF_CP_CTRL:    rd_data = r.cp_ctrl;
         `LFI_OFF_BANK_EN:    rd_data = r.bank_en;
         `LFI_OFF_BOOST_CTRL: rd_data = r.boost_ctrl;
         `LFI_OFF_BRT_A:      rd_data = r.brt_a;
         default:             rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic open_en;
      logic short_en;
      next_r = r;
      open_en  = r.fault_en[`LFI_FEN_OPEN];
      short_en = r.fault_en[`LFI_FEN_SHORT];
      next_r.scl_s = {r.scl_s[0], scl_in};
      next_r.sda_s = {r.sda_s[0], sda_in};
      next_r.scl_d = r.scl_s[1];
      next_r.sda_d = r.sda_s[1];
      next_r.ana_s0_pad = 2'b00;
      // Comparators are asynchronous; two stages before any use
      next_r.ana_s1 = analog_in;
      next_r.ana_s2 = r.ana_s1;

      // Fault flags follow the comparators only while armed
      next_r.hv_short = short_en ? r.ana_s2.hv_string_short : 3'h0;
      next_r.lv_short = short_en ? r.ana_s2.lv_below_1v : 6'h0;
      next_r.lv_open  = open_en ? r.ana_s2.lv_below_headroom : 6'h0;
      next_r.hv_open  = (open_en && r.ana_s2.ovp_reached) ?
                        r.ana_s2.hv_low_200mv : 3'h0;

      // Overvoltage hysteresis: stop at limit, resume 1 V below
      if (r.ana_s2.ovp_reached)
         next_r.ovp_stop = 1'b1;
      else if (r.ana_s2.ovp_below_hyst)
         next_r.ovp_stop = 1'b0;
      // Overcurrent blanks the rest of the cycle only
      if (pwm_cycle_start)
         next_r.ocp_off = 1'b0;
      else if (r.ana_s2.sw_over_1a)
         next_r.ocp_off = 1'b1;

      // Serial slave
      if (start_cond) begin
         next_r.state    = LFI_ADDR;
         next_r.bitcnt   = 4'h0;
         next_r.byte_idx = 2'h0;
         next_r.sda_low  = 1'b0;
      end else if (stop_cond) begin
         next_r.state   = LFI_IDLE;
         next_r.sda_low = 1'b0;
      end else begin
         unique case (r.state)
            LFI_IDLE: begin
               next_r.sda_low = 1'b0;
            end
            LFI_ADDR: begin
               // Sample on SCL rise, MSB first
               if (scl_rise) begin
                  next_r.shreg  = {r.shreg[6:0], r.sda_s[1]};
                  next_r.bitcnt = 4'(r.bitcnt + 4'h1);
               end
               if (scl_fall && r.bitcnt == 4'h8) begin
                  next_r.bitcnt = 4'h0;
                  if (r.byte_idx == 2'h0 &&
                      r.shreg[7:1] != `LFI_SLAVE_ADDR) begin
                     next_r.state = LFI_SKIP;
                  end else begin
                     next_r.state   = LFI_ACK;
                     next_r.sda_low = 1'b1;
                     if (r.byte_idx == 2'h0)
                        next_r.rw = r.shreg[0];
                     else if (r.byte_idx == 2'h1)
                        next_r.reg_ptr = r.shreg;
                     else begin
                        unique case (r.reg_ptr)
                           `LFI_OFF_FAULT_EN:   next_r.fault_en = r.shreg;
                           `LFI_OFF_HV_CFG:     next_r.hv_cfg = r.shreg;
                           `LFI_OFF_LV_CFG:     next_r.lv_cfg = r.shreg;
                           `LFI_OFF_FS_A:       next_r.fs_a = r.shreg;
                           `LFI_OFF_HV_FB:      next_r.hv_fb = r.shreg;
                           `LFI_OFF_CP_CTRL:    next_r.cp_ctrl = r.shreg;
                           `LFI_OFF_BANK_EN:    next_r.bank_en = r.shreg;
                           `LFI_OFF_BOOST_CTRL: next_r.boost_ctrl = r.shreg;
                           `LFI_OFF_BRT_A:      next_r.brt_a = r.shreg;
                           default:             ;
                        endcase
                        next_r.reg_ptr = 8'(r.reg_ptr + 8'h01);
                     end
                  end
               end
            end
            LFI_ACK: begin
               // After the ninth clock release, or drive the first read bit; SDA moves only with SCL low
               if (scl_fall) begin
                  if (r.byte_idx == 2'h0 && r.rw) begin
                     next_r.state   = LFI_RD;
                     next_r.shreg   = rd_data;
                     next_r.sda_low = ~rd_data[7];
                     next_r.bitcnt  = 4'h1;
                     next_r.reg_ptr = 8'(r.reg_ptr + 8'h01);
                  end else begin
                     next_r.state   = LFI_ADDR;
                     next_r.sda_low = 1'b0;
                  end
                  if (r.byte_idx != 2'h2)
                     next_r.byte_idx = 2'(r.byte_idx + 2'h1);
               end
            end
            LFI_RD: begin
               // Shift read data out; master ack slot drives nothing
               if (scl_fall) begin
                  if (r.bitcnt == 4'h8) begin
                     next_r.sda_low = 1'b0;
                     next_r.bitcnt  = 4'(r.bitcnt + 4'h1);
                  end else if (r.bitcnt == 4'h9) begin
                     next_r.shreg   = rd_data;
                     next_r.sda_low = ~rd_data[7];
                     next_r.bitcnt  = 4'h1;
                     next_r.reg_ptr = 8'(r.reg_ptr + 8'h01);
                  end else begin
                     next_r.sda_low = ~r.shreg[6];
                     next_r.shreg   = {r.shreg[6:0], 1'b0};
                     next_r.bitcnt  = 4'(r.bitcnt + 4'h1);
                  end
               end
               // Master NACK ends the read
               if (scl_rise && r.bitcnt == 4'h9 && r.sda_s[1])
                  next_r.state = LFI_SKIP;
            end
            LFI_SKIP: begin
               next_r.sda_low = 1'b0;
            end
            default: begin
               next_r.state = LFI_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         r            <= '0;
         r.scl_s      <= 2'b11;
         r.sda_s      <= 2'b11;
         r.scl_d      <= 1'b1;
         r.sda_d      <= 1'b1;
         r.state      <= LFI_IDLE;
         r.fault_en   <= `LFI_RST_FAULT_EN;
         r.hv_cfg     <= `LFI_RST_HV_CFG;
         r.lv_cfg     <= `LFI_RST_LV_CFG;
         r.fs_a       <= `LFI_RST_FS;
         r.hv_fb      <= `LFI_RST_HV_FB;
         r.cp_ctrl    <= `LFI_RST_CP_CTRL;
         r.bank_en    <= `LFI_RST_BANK_EN;
         r.boost_ctrl <= `LFI_RST_BOOST_CTRL;
         r.brt_a      <= `LFI_RST_BRT;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open drain: only ever drive low
   assign sda_out  = 1'b0;
   assign sda_oe   = r.sda_low;
   assign bus_busy = (r.state != LFI_IDLE);
   assign boost_switch_en = ~r.ovp_stop & ~r.ocp_off;
   // Zero select means the lowest limit, the reset value; one bit per step
   assign ctrl_out.ovp_sel = 4'(1) <<
                  r.boost_ctrl[`LFI_OVP_MSB:`LFI_OVP_LSB];
   assign ctrl_out.cp_gain =
                  r.cp_ctrl[`LFI_CP_GAIN_MSB:`LFI_CP_GAIN_LSB];
   assign ctrl_out.hv_feedback  = r.hv_fb[2:0];
   assign ctrl_out.hv_to_bank_a = ~r.hv_cfg[2:0];
   assign ctrl_out.lv_bank_cf   = r.lv_cfg[5:0];
   assign ctrl_out.bank_en = {r.bank_en[`LFI_BANK_F],
                              r.bank_en[`LFI_BANK_C],
                              r.bank_en[`LFI_BANK_A]};
endmodule

/* tb/lfi_fault_port_properties.sv */
// Port-level checker for the fault flag and serial port block
`timescale 1ns/1ps
module lfi_fault_port_properties
   import lfi_pkg::*;
(
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire lfi_analog_t analog_in,
   input wire logic        pwm_cycle_start,
   input wire logic        boost_switch_en,
   input wire lfi_ctrl_t   ctrl_out,
   input wire logic        bus_busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // -------------------------------------------------------------------
   // Bus pin discipline
   // -------------------------------------------------------------------
   // Slave data may only move while the clock is low
   property p_oe_scl_low;
      $changed(sda_oe) |-> !scl_in;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("oe moved, scl high");
   property p_oe_in_frame;
      sda_oe |-> bus_busy;
   endproperty
   a_oe_in_frame: assert property (p_oe_in_frame) else $error("oe off frame");
   property p_busy_start;
      scl_in && $fell(sda_in) |-> ##[1:5] bus_busy;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy late");
   property p_busy_stop;
      scl_in && $rose(sda_in) |-> ##[1:5] !bus_busy;
   endproperty
   a_busy_stop: assert property (p_busy_stop) else $error("busy stuck");
   // Config only changes inside a write frame
   property p_ctrl_idle;
      $changed(ctrl_out) |-> bus_busy;
   endproperty
   a_ctrl_idle: assert property (p_ctrl_idle) else $error("ctrl moved idle");
   property p_reset_dflt;
      $rose(resetn) |-> !sda_oe && !bus_busy && boost_switch_en
         && ctrl_out.ovp_sel == 4'b0001 && ctrl_out.bank_en == 3'b000;
   endproperty
   a_reset_dflt: assert property (p_reset_dflt) else $error("bad default");
   // -------------------------------------------------------------------
   // Boost protection
   // -------------------------------------------------------------------
   property p_ovp_stop;
      $rose(analog_in.ovp_reached) |-> ##[1:5] !boost_switch_en;
   endproperty
   a_ovp_stop: assert property (p_ovp_stop) else $error("ovp no stop");
   property p_ocp_stop;
      $rose(analog_in.sw_over_1a) |-> ##[1:5] !boost_switch_en;
   endproperty
   a_ocp_stop: assert property (p_ocp_stop) else $error("ocp no stop");
   c_start: cover property (scl_in && $fell(sda_in));
   c_ack: cover property ($rose(sda_oe));
   c_off: cover property ($fell(boost_switch_en));
endmodule
bind lfi_fault_port lfi_fault_port_properties u_props (
   .mclk, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe, .analog_in,
   .pwm_cycle_start, .boost_switch_en, .ctrl_out, .bus_busy
);

/* tb/lfi_host_model.sv */
// Two-wire bus master model standing in for the host controller
`timescale 1ns/1ps
`include "lfi_defs.svh"
module lfi_host_model (
   input  wire logic  mclk,
   input  wire logic  sda_line,
   output logic       scl,
   output logic       sda_low,
   output logic       rd_done,
   output logic [7:0] rd_data
);
   // Half period well above the slave's synchroniser lag
   localparam int HALF = 8;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      rd_done = 1'b0;
      rd_data = 8'h00;
   end
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Data moves halfway into the low phase, never beside an edge
   task automatic put_bit(input logic b, output logic r);
      sda_low <= ~b;
      wait_n(HALF / 2);
      scl <= 1'b1;
      wait_n(HALF);
      r = sda_line;
      scl <= 1'b0;
      wait_n(HALF / 2);
   endtask
   // Serves as START and as repeated START from a low clock
   task automatic start_cond();
      sda_low <= 1'b0;
      wait_n(HALF / 2);
      scl <= 1'b1;
      wait_n(HALF);
      sda_low <= 1'b1;
      wait_n(HALF);
      scl <= 1'b0;
      wait_n(HALF / 2);
   endtask
   task automatic stop_cond();
      sda_low <= 1'b1;
      wait_n(HALF / 2);
      scl <= 1'b1;
      wait_n(HALF);
      sda_low <= 1'b0;
      wait_n(HALF);
   endtask
   // Eight bits, then a ninth clock with the line released
   task automatic put_byte(input logic [7:0] b, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], r);
      end
      put_bit(1'b1, nack);
   endtask
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                            input logic [7:0] d, output logic [2:0] nack);
      start_cond();
      put_byte({dev, 1'b0}, nack[2]);
      put_byte(a, nack[1]);
      put_byte(d, nack[0]);
      stop_cond();
   endtask
   // Pointer write, repeated START, one byte, NACK, STOP
   task automatic read_reg(input logic [7:0] a);
      logic       k;
      logic [7:0] d;
      start_cond();
      put_byte({`LFI_SLAVE_ADDR, 1'b0}, k);
      put_byte(a, k);
      start_cond();
      put_byte({`LFI_SLAVE_ADDR, 1'b1}, k);
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, d[i]);
      end
      put_bit(1'b1, k);
      stop_cond();
      rd_data <= d;
      rd_done <= 1'b1;
      wait_n(1);
      rd_done <= 1'b0;
   endtask
endmodule

/* tb/lfi_fault_port_tb.sv */
// Self-checking bench for the fault flag and serial port block
`timescale 1ns/1ps
`include "lfi_defs.svh"
module lfi_fault_port_tb;
   import lfi_pkg::*;
   logic        mclk;
   logic        resetn;
   logic        sda_out;
   logic        sda_oe;
   logic        pwm_cycle_start;
   logic        boost_switch_en;
   logic        bus_busy;
   logic        scl;
   logic        sda_low;
   logic        rd_done;
   logic [7:0]  rd_data;
   wire logic   sda_line;
   lfi_analog_t analog_in;
   lfi_ctrl_t   ctrl_out;
   logic [2:0]  nack;
   logic [7:0]  exp_q[$];
   int          err_count;
   int          n_compared;
   int          cycles;
   // Pulled-up data line, low while either side pulls
   assign sda_line = ~(sda_low | sda_oe);
   lfi_fault_port u_dut (
      .mclk, .resetn, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
      .analog_in, .pwm_cycle_start, .boost_switch_en, .ctrl_out, .bus_busy
   );
   lfi_host_model u_host (
      .mclk, .sda_line, .scl, .sda_low, .rd_done, .rd_data
   );
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d, mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.write_reg(`LFI_SLAVE_ADDR, a, d, nack);
      check({5'h00, nack}, 8'h00);
      check({7'h00, sda_out}, 8'h00);
      u_host.wait_n(4);
      check({7'h00, bus_busy}, 8'h00);
   endtask
   // Driver notes the expectation, the scoreboard compares it
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.read_reg(a);
   endtask
   always @(posedge mclk) begin
      if (rd_done === 1'b1) begin
         check(rd_data, exp_q.pop_front());
      end
   end
   // Hang guard, generous against the longest run
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 80000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      logic [7:0] fe;
      logic [2:0] hv_lo;
      logic [2:0] hv_sh;
      logic [5:0] lv_hr;
      logic [5:0] lv_1v;
      logic       overvoltage_limit;
      resetn = 1'b0;
      pwm_cycle_start = 1'b0;
      analog_in = '0;
      err_count = 0;
      n_compared = 0;
      cycles = 0;
      void'($urandom(92156));
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      u_host.wait_n(4);
      // Defaults and control decode
      check({4'h0, ctrl_out.ovp_sel}, 8'h01);
      rd(`LFI_OFF_HV_CFG, `LFI_RST_HV_CFG);
      rd(`LFI_OFF_HV_FB, `LFI_RST_HV_FB);
      wr(`LFI_OFF_BANK_EN, 8'h25);
      check({5'h00, ctrl_out.bank_en}, 8'h07);
      wr(`LFI_OFF_CP_CTRL, 8'h06);
      check({6'h00, ctrl_out.cp_gain}, 8'h03);
      wr(`LFI_OFF_CP_CTRL, 8'h40);
      check({6'h00, ctrl_out.cp_gain}, 8'h00);
      wr(`LFI_OFF_HV_CFG, 8'h06);
      check({5'h00, ctrl_out.hv_to_bank_a}, 8'h01);
      wr(`LFI_OFF_LV_CFG, 8'h00);
      rd(`LFI_OFF_LV_CFG, 8'h00);
      wr(`LFI_OFF_BRT_A, 8'hff);
      rd(`LFI_OFF_BRT_A, 8'hff);
      wr(`LFI_OFF_BOOST_CTRL, 8'h06);
      rd(`LFI_OFF_BOOST_CTRL, 8'h06);
      check({4'h0, ctrl_out.ovp_sel}, 8'h08);
      wr(`LFI_OFF_BANK_EN, 8'h00);
      check({5'h00, ctrl_out.bank_en}, 8'h00);
      $display("test controls done");
      // Fault flags under each enable setting, one short string
      for (int k = 0; k < 4; k++) begin
         fe = 8'(k);
         hv_lo = 3'($urandom);
         hv_sh = 3'(1 << ($urandom % 3));
         lv_hr = 6'($urandom);
         lv_1v = 6'($urandom);
         overvoltage_limit = 1'($urandom);
         analog_in <= '{hv_lo, hv_sh, lv_hr, lv_1v, overvoltage_limit, 1'b0, 1'b0};
         wr(`LFI_OFF_FAULT_EN, fe);
         rd(`LFI_OFF_FAULT_EN, fe);
         rd(`LFI_OFF_HV_OPEN, (fe[0] && overvoltage_limit) ? {5'h00, hv_lo} : 8'h00);
         rd(`LFI_OFF_LV_OPEN, fe[0] ? {2'b00, lv_hr} : 8'h00);
         rd(`LFI_OFF_HV_SHORT, fe[1] ? {5'h00, hv_sh} : 8'h00);
         rd(`LFI_OFF_LV_SHORT, fe[1] ? {2'b00, lv_1v} : 8'h00);
      end
      $display("test fault flags done");
      // Unmapped place and a foreign slave address
      wr(8'h05, 8'haa);
      rd(8'h05, 8'h00);
      u_host.write_reg(7'h37, `LFI_OFF_FAULT_EN, 8'h00, nack);
      check({5'h00, nack}, 8'h07);
      rd(`LFI_OFF_FAULT_EN, 8'h03);
      $display("test addressing done");
      // Overvoltage hysteresis, then repeated overcurrent cycles
      analog_in <= '{hv_lo, hv_sh, lv_hr, lv_1v, 1'b0, 1'b1, 1'b0};
      u_host.wait_n(6);
      check({7'h00, boost_switch_en}, 8'h01);
      analog_in.ovp_below_hyst <= 1'b0;
      analog_in.ovp_reached <= 1'b1;
      u_host.wait_n(6);
      check({7'h00, boost_switch_en}, 8'h00);
      analog_in.ovp_reached <= 1'b0;
      u_host.wait_n(6);
      check({7'h00, boost_switch_en}, 8'h00);
      analog_in.ovp_below_hyst <= 1'b1;
      u_host.wait_n(6);
      check({7'h00, boost_switch_en}, 8'h01);
      analog_in.ovp_below_hyst <= 1'b0;
      for (int c = 0; c < 2; c++) begin
         analog_in.sw_over_1a <= 1'b1;
         u_host.wait_n(1);
         analog_in.sw_over_1a <= 1'b0;
         u_host.wait_n(8);
         check({7'h00, boost_switch_en}, 8'h00);
         pwm_cycle_start <= 1'b1;
         u_host.wait_n(1);
         pwm_cycle_start <= 1'b0;
         u_host.wait_n(2);
         check({7'h00, boost_switch_en}, 8'h01);
      end
      $display("test protection done");
      // Second reset in mid-run restores the enables
      resetn <= 1'b0;
      u_host.wait_n(3);
      resetn <= 1'b1;
      u_host.wait_n(4);
      rd(`LFI_OFF_FAULT_EN, `LFI_RST_FAULT_EN);
      u_host.wait_n(4);
      check(8'(exp_q.size()), 8'h00);
      $display("test reset done");
      complete_run();
   end
endmodule
